// >>> hw/tsic_top.sv
// trap status and interrupt control register group with AXI4-Lite slave
// How it works
// (RULE1) address fault flag at bit 3
// (RULE2) stack fault flag at bit 2
// (RULE3) oscillator fault flag at bit 1
// (RULE4) unimplemented bits read zero, ignore writes
// (RULE5) global enable resets one, gates interrupts; here it is only driven out, o_ext_irq_edge is not gated by it
// (RULE6) bit 14 shows temporary block active
// (RULE7) bit 13 software trap enable and request
// (RULE8) polarity bits: one falling, zero rising
// (RULE9) dma address fault flag at bit 5
// (RULE10) loop stack overflow flag at bit 4
// (RULE11) soft generated hard fault at bit 0
// (RULE12) new priority level in bits 11..8
// (RULE13) pending vector code in bits 6..0
// (RULE14) trap flags stick until software writes zero
// (RULE15) sixteen bit registers, single word accesses; here writes follow the byte strobes per lane
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module tsic_top
  import tsic_pkg::*;
#(
  parameter int NUM_EXT = TSIC_NUM_EXT
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_ce,
  // trap and state inputs from the core
  input  wire logic                  i_addr_fault,
  input  wire logic                  i_stack_fault,
  input  wire logic                  i_osc_fault,
  input  wire logic                  i_dma_fault,
  input  wire logic                  i_loop_ovf,
  input  wire logic                  i_soft_hard_fault,
  input  wire logic                  i_temp_block,
  input  wire logic [TSIC_IPL_W-1:0] i_new_ipl,
  input  wire logic [TSIC_VEC_W-1:0] i_vec_code,
  input  wire logic [NUM_EXT-1:0]    i_ext_irq,
  // AXI4-Lite slave
  input  wire logic [4:0]            i_awaddr,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [4:0]            i_araddr,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  // outputs to the core
  output logic                       o_global_irq_enable,
  output logic                       o_software_trap_control,
  output logic [NUM_EXT-1:0]         o_ext_irq_edge
);
  // -------------------------------------------------------------------
  // write channel: capture address and data in either order
  // -------------------------------------------------------------------
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [4:0]  aw_addr_q, aw_addr_d;
  logic [15:0] w_data_q, w_data_d;
  logic [1:0]  w_strb_q, w_strb_d;
  logic        bvalid_d;
  logic [1:0]  bresp_d;
  logic        do_wr;
  logic        wr_hit;
  assign do_wr  = aw_full_q && w_full_q && !o_bvalid;
  assign wr_hit = (aw_addr_q == TSIC_ADDR_CTL1) || (aw_addr_q == TSIC_ADDR_CTL2) ||
                  (aw_addr_q == TSIC_ADDR_CTL3) || (aw_addr_q == TSIC_ADDR_CTL4) ||
                  (aw_addr_q == TSIC_ADDR_STAT);
  // one write at a time: ready drops while a word is held
  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = o_bvalid;
    bresp_d   = o_bresp;
    if (i_awvalid && o_awready) begin
      aw_full_d = 1'b1;
      aw_addr_d = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_full_d = 1'b1;
      w_data_d = i_wdata[15:0];
      w_strb_d = i_wstrb[1:0];
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? TSIC_RESP_OKAY : TSIC_RESP_SLV;
    end else if (o_bvalid && i_bready) begin
      bvalid_d = 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_full_q  <= 1'b0;
      w_data_q  <= 16'h0000;
      w_strb_q  <= 2'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= TSIC_RESP_OKAY;
    end else if (i_ce) begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q  <= w_full_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      o_bvalid  <= bvalid_d;
      o_bresp   <= bresp_d;
    end
  end
  // ready is held low while the slot is full, registered from state
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
    end else if (i_ce) begin
      o_awready <= !aw_full_d && !(i_awvalid && o_awready);
      o_wready  <= !w_full_d && !(i_wvalid && o_wready);
    end
  end
  // -------------------------------------------------------------------
  // per-register write strobes, per byte lane
  // -------------------------------------------------------------------
  logic wr_c1_lo, wr_c2_lo, wr_c2_hi, wr_c3_lo, wr_c4_lo;
  assign wr_c1_lo = do_wr && (aw_addr_q == TSIC_ADDR_CTL1) && w_strb_q[0];
  assign wr_c2_lo = do_wr && (aw_addr_q == TSIC_ADDR_CTL2) && w_strb_q[0];
  assign wr_c2_hi = do_wr && (aw_addr_q == TSIC_ADDR_CTL2) && w_strb_q[1];
  assign wr_c3_lo = do_wr && (aw_addr_q == TSIC_ADDR_CTL3) && w_strb_q[0];
  assign wr_c4_lo = do_wr && (aw_addr_q == TSIC_ADDR_CTL4) && w_strb_q[0];
  // -------------------------------------------------------------------
  // sticky trap flags
  // -------------------------------------------------------------------
  logic addr_fault_flag, stack_fault_flag, oscillator_fault_flag;
  logic dma_address_fault_flag, loop_stack_overflow_flag;
  logic soft_generated_hard_fault_flag;
  // (RULE1) address fault capture
  tsic_sticky_flag u_addr (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_set     (i_addr_fault), .i_wr (wr_c1_lo),
    .i_wr_val  (w_data_q[TSIC_BIT_ADDR_FAULT]), .o_flag (addr_fault_flag));
  // (RULE2) stack fault capture
  tsic_sticky_flag u_stack (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_set     (i_stack_fault), .i_wr (wr_c1_lo),
    .i_wr_val  (w_data_q[TSIC_BIT_STACK_FAULT]), .o_flag (stack_fault_flag));
  // (RULE3) oscillator fault capture
  tsic_sticky_flag u_osc (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_set     (i_osc_fault), .i_wr (wr_c1_lo),
    .i_wr_val  (w_data_q[TSIC_BIT_OSC_FAULT]), .o_flag (oscillator_fault_flag));
  // (RULE9) dma fault capture
  tsic_sticky_flag u_dma (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_set     (i_dma_fault), .i_wr (wr_c3_lo),
    .i_wr_val  (w_data_q[TSIC_BIT_DMA_FAULT]), .o_flag (dma_address_fault_flag));
  // (RULE10) loop overflow capture
  tsic_sticky_flag u_loop (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_set     (i_loop_ovf), .i_wr (wr_c3_lo),
    .i_wr_val  (w_data_q[TSIC_BIT_LOOP_OVF]), .o_flag (loop_stack_overflow_flag));
  // (RULE11) soft hard-fault capture
  tsic_sticky_flag u_soft_hard (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_set     (i_soft_hard_fault), .i_wr (wr_c4_lo),
    .i_wr_val  (w_data_q[TSIC_BIT_SOFT_HARD]), .o_flag (soft_generated_hard_fault_flag));
  // -------------------------------------------------------------------
  // control bits of the second register
  // -------------------------------------------------------------------
  logic               glb_en_d, sw_trap_d;
  logic [NUM_EXT-1:0] pol_q, pol_d;
  // (RULE5) global enable, written by software
  // (RULE7) software trap enable raises the trap request
  // (RULE8) polarity bits in the low byte
  always_comb begin
    glb_en_d  = o_global_irq_enable;
    sw_trap_d = o_software_trap_control;
    pol_d     = pol_q;
    if (wr_c2_hi) begin
      glb_en_d  = w_data_q[TSIC_BIT_GLB_EN];
      sw_trap_d = w_data_q[TSIC_BIT_SW_TRAP];
    end
    if (wr_c2_lo) begin
      pol_d = w_data_q[NUM_EXT-1:0];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_global_irq_enable     <= TSIC_GLB_EN_RST;
      o_software_trap_control <= 1'b0;
      pol_q                   <= NUM_EXT'(TSIC_POL_RST);
    end else if (i_ce) begin
      o_global_irq_enable     <= glb_en_d;
      o_software_trap_control <= sw_trap_d;
      pol_q                   <= pol_d;
    end
  end
  // -------------------------------------------------------------------
  // external edge detect with selectable polarity
  // -------------------------------------------------------------------
  logic [NUM_EXT-1:0] ext_prev_q, edge_d;
  logic               ext_primed_q;  // a line high at reset release is not an edge
  // (RULE8) falling edge when polarity is one, rising when zero
  always_comb begin
    for (int k = 0; k < NUM_EXT; k++) begin
      if (pol_q[k] == TSIC_EDGE_FALL) begin
        edge_d[k] = ext_primed_q && ext_prev_q[k] && !i_ext_irq[k];
      end else begin
        edge_d[k] = ext_primed_q && !ext_prev_q[k] && i_ext_irq[k];
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_primed_q   <= 1'b0;
      ext_prev_q     <= '0;
      o_ext_irq_edge <= '0;
    end else if (i_ce) begin
      ext_primed_q   <= 1'b1;
      ext_prev_q     <= i_ext_irq;
      o_ext_irq_edge <= edge_d;
    end
  end
  // -------------------------------------------------------------------
  // read channel
  // -------------------------------------------------------------------
  logic [15:0] rd_word;
  logic        rd_hit;
  logic        rvalid_d, arready_d;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_d;
  // (RULE4) only implemented bits are placed, the rest stay zero
  // (RULE6) live temporary block status on bit 14
  // (RULE12) priority level field
  // (RULE13) vector code field, bit 7 zero
  always_comb begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    case (i_araddr)
      TSIC_ADDR_CTL1: begin
        rd_word[TSIC_BIT_ADDR_FAULT]  = addr_fault_flag;
        rd_word[TSIC_BIT_STACK_FAULT] = stack_fault_flag;
        rd_word[TSIC_BIT_OSC_FAULT]   = oscillator_fault_flag;
      end
      TSIC_ADDR_CTL2: begin
        rd_word[TSIC_BIT_GLB_EN]     = o_global_irq_enable;
        rd_word[TSIC_BIT_TEMP_BLOCK] = i_temp_block;
        rd_word[TSIC_BIT_SW_TRAP]    = o_software_trap_control;
        rd_word[NUM_EXT-1:0]         = pol_q;
      end
      TSIC_ADDR_CTL3: begin
        rd_word[TSIC_BIT_DMA_FAULT] = dma_address_fault_flag;
        rd_word[TSIC_BIT_LOOP_OVF]  = loop_stack_overflow_flag;
      end
      TSIC_ADDR_CTL4: begin
        rd_word[TSIC_BIT_SOFT_HARD] = soft_generated_hard_fault_flag;
      end
      TSIC_ADDR_STAT: begin
        rd_word[TSIC_IPL_LSB +: TSIC_IPL_W] = i_new_ipl;
        rd_word[TSIC_VEC_W-1:0]             = i_vec_code;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end
  // (RULE15) one sixteen bit word per access, upper half zero
  always_comb begin
    rvalid_d  = o_rvalid;
    rdata_d   = o_rdata;
    rresp_d   = o_rresp;
    arready_d = !o_rvalid;
    if (i_arvalid && o_arready) begin
      rvalid_d  = 1'b1;
      rdata_d   = {16'h0000, rd_word};
      rresp_d   = rd_hit ? TSIC_RESP_OKAY : TSIC_RESP_SLV;
      arready_d = 1'b0;
    end else if (o_rvalid && i_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= TSIC_RESP_OKAY;
      o_arready <= 1'b0;
    end else if (i_ce) begin
      o_rvalid  <= rvalid_d;
      o_rdata   <= rdata_d;
      o_rresp   <= rresp_d;
      o_arready <= arready_d;
    end
  end
  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  sequence s_fault_seen;
    i_ce && i_addr_fault;
  endsequence
  sequence s_wr_taken;
    i_ce && do_wr;
  endsequence
  addr_flag_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE1
    s_fault_seen |=> addr_fault_flag) else $error("address fault flag not set");
  stack_flag_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE2
    i_ce && i_stack_fault |=> stack_fault_flag) else $error("stack fault flag not set");
  osc_flag_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE3
    i_ce && i_osc_fault |=> oscillator_fault_flag) else $error("osc fault flag not set");
  upper_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE4
    o_rvalid |-> o_rdata[31:16] == 16'h0000 && !(o_rdata[12:3] != 10'h000
      && $past(i_araddr) == TSIC_ADDR_CTL2 && o_rresp == TSIC_RESP_OKAY && $rose(o_rvalid)))
    else $error("unimplemented bits read nonzero");
  glb_en_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE5
    s_wr_taken and wr_c2_hi |=> o_global_irq_enable == $past(w_data_q[TSIC_BIT_GLB_EN]))
    else $error("global enable write lost");
  dma_flag_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE9
    i_ce && i_dma_fault |=> dma_address_fault_flag) else $error("dma flag not set");
  loop_flag_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE10
    i_ce && i_loop_ovf |=> loop_stack_overflow_flag) else $error("loop flag not set");
  soft_hard_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE11
    i_ce && i_soft_hard_fault |=> soft_generated_hard_fault_flag)
    else $error("soft hard fault flag not set");
  flag_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE14
    addr_fault_flag && !wr_c1_lo |=> addr_fault_flag) else $error("flag dropped alone");
  edge_fall_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE8
    i_ce && pol_q[0] && ext_prev_q[0] && !i_ext_irq[0] |=> o_ext_irq_edge[0])
    else $error("falling edge missed");
  wr_resp_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE15
    s_wr_taken |=> o_bvalid) else $error("write response late");
endmodule

// >>> hw/tsic_pkg.sv
// constants for the trap status and interrupt control register group
package tsic_pkg;
  // -------------------------------------------------------------------
  // register byte addresses (one aligned word each)
  // -------------------------------------------------------------------
  localparam logic [4:0] TSIC_ADDR_CTL1  = 5'h00;
  localparam logic [4:0] TSIC_ADDR_CTL2  = 5'h04;
  localparam logic [4:0] TSIC_ADDR_CTL3  = 5'h08;
  localparam logic [4:0] TSIC_ADDR_CTL4  = 5'h0C;
  localparam logic [4:0] TSIC_ADDR_STAT  = 5'h10;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int TSIC_BIT_ADDR_FAULT  = 3;
  localparam int TSIC_BIT_STACK_FAULT = 2;
  localparam int TSIC_BIT_OSC_FAULT   = 1;
  localparam int TSIC_BIT_GLB_EN      = 15;
  localparam int TSIC_BIT_TEMP_BLOCK  = 14;
  localparam int TSIC_BIT_SW_TRAP     = 13;
  localparam int TSIC_BIT_DMA_FAULT   = 5;
  localparam int TSIC_BIT_LOOP_OVF    = 4;
  localparam int TSIC_BIT_SOFT_HARD   = 0;
  localparam int TSIC_IPL_LSB         = 8;
  localparam int TSIC_IPL_W           = 4;
  localparam int TSIC_VEC_W           = 7;
  localparam int TSIC_NUM_EXT         = 3;
  // -------------------------------------------------------------------
  // reset values and bus answers
  // -------------------------------------------------------------------
  localparam logic       TSIC_GLB_EN_RST = 1'b1;
  localparam logic [2:0] TSIC_POL_RST   = 3'h0;
  localparam logic [1:0] TSIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSIC_RESP_SLV  = 2'h2;
  typedef enum logic [0:0] {
    TSIC_EDGE_RISE = 1'b0,
    TSIC_EDGE_FALL = 1'b1
  } tsic_edge_t;
endpackage

// >>> hw/tsic_sticky_flag.sv
// one sticky trap flag: hardware sets, software clears by writing zero
`timescale 1ns/1ps
module tsic_sticky_flag (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_ce,
  input  wire logic i_set,
  input  wire logic i_wr,
  input  wire logic i_wr_val,
  output logic      o_flag
);
  logic flag_d;
  // (RULE14) sticky until cleared
  // set wins over a clearing write in the same cycle
  always_comb begin
    flag_d = o_flag;
    if (i_wr) begin
      flag_d = i_wr_val;
    end
    if (i_set) begin
      flag_d = 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flag <= 1'b0;
    end else if (i_ce) begin
      o_flag <= flag_d;
    end
  end
endmodule

// >>> bench/tsic_core_model.sv
// behavioural model of the core and trap sources that feed the block
`timescale 1ns/1ps
module tsic_core_model
  import tsic_pkg::*;
(
  input  wire logic               i_sys_clk,
  output logic [5:0]              o_trap,
  output logic                    o_temp_block,
  output logic [TSIC_IPL_W-1:0]   o_new_ipl,
  output logic [TSIC_VEC_W-1:0]   o_vec_code,
  output logic [TSIC_NUM_EXT-1:0] o_ext_irq
);
  // all lines start quiet so nothing reaches the block unknown
  initial begin
    o_trap       = 6'h00;
    o_temp_block = 1'b0;
    o_new_ipl    = 4'h0;
    o_vec_code   = 7'h00;
    o_ext_irq    = 3'h0;
  end
  // a single-cycle event: the hardest case for a sticky flag to catch
  task automatic fire(input int i);
    @(posedge i_sys_clk);
    o_trap <= 6'h01 << i;
    @(posedge i_sys_clk);
    o_trap <= 6'h00;
  endtask
  // core state that the block only mirrors
  task automatic set_state(input logic b, input logic [3:0] p, input logic [6:0] v);
    @(posedge i_sys_clk);
    o_temp_block <= b;
    o_new_ipl    <= p;
    o_vec_code   <= v;
  endtask
  task automatic set_ext(input logic [2:0] v);
    @(posedge i_sys_clk);
    o_ext_irq <= v;
  endtask
endmodule

// >>> bench/test_trap_status_and_interrupt_control.sv
// self-checking bench for the trap status and interrupt control block
`timescale 1ns/1ps
module test_trap_status_and_interrupt_control
  import tsic_pkg::*;
;
  typedef struct {
    logic [4:0]  a;
    logic [15:0] d;
    logic [15:0] e;
    logic [1:0]  r;
  } tsic_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        ce = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, glb_en, swt;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  edges, ext;
  logic [5:0]  trap;
  logic        blk;
  logic [3:0]  ipl;
  logic [6:0]  vec;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [31:0] v;
  logic [1:0]  r;
  logic [4:0]  fa[6] = '{TSIC_ADDR_CTL1, TSIC_ADDR_CTL1, TSIC_ADDR_CTL1,
                         TSIC_ADDR_CTL3, TSIC_ADDR_CTL3, TSIC_ADDR_CTL4};
  int          fb[6] = '{TSIC_BIT_ADDR_FAULT, TSIC_BIT_STACK_FAULT, TSIC_BIT_OSC_FAULT,
                         TSIC_BIT_DMA_FAULT, TSIC_BIT_LOOP_OVF, TSIC_BIT_SOFT_HARD};
  tsic_row_t   rows[9] = '{
    '{TSIC_ADDR_CTL2, 16'hFFFF, 16'hA007, TSIC_RESP_OKAY},
    '{TSIC_ADDR_CTL2, 16'h0000, 16'h0000, TSIC_RESP_OKAY},
    '{TSIC_ADDR_CTL1, 16'hFFFF, 16'h000E, TSIC_RESP_OKAY},
    '{TSIC_ADDR_CTL1, 16'h0000, 16'h0000, TSIC_RESP_OKAY},
    '{TSIC_ADDR_CTL3, 16'hFFFF, 16'h0030, TSIC_RESP_OKAY},
    '{TSIC_ADDR_CTL3, 16'h0000, 16'h0000, TSIC_RESP_OKAY},
    '{TSIC_ADDR_CTL4, 16'hFFFF, 16'h0001, TSIC_RESP_OKAY},
    '{TSIC_ADDR_CTL4, 16'h0000, 16'h0000, TSIC_RESP_OKAY},
    '{5'h14,          16'hFFFF, 16'h0000, TSIC_RESP_SLV}};

  // 100 MHz clock
  always #5 clk = ~clk;

  tsic_core_model core (
    .i_sys_clk    (clk),
    .o_trap       (trap),
    .o_temp_block (blk),
    .o_new_ipl    (ipl),
    .o_vec_code   (vec),
    .o_ext_irq    (ext)
  );

  tsic_top dut (
    .i_sys_clk (clk), .i_reset_n (rst_n), .i_ce (ce),
    .i_addr_fault (trap[0]), .i_stack_fault (trap[1]), .i_osc_fault (trap[2]),
    .i_dma_fault (trap[3]), .i_loop_ovf (trap[4]), .i_soft_hard_fault (trap[5]),
    .i_temp_block (blk), .i_new_ipl (ipl), .i_vec_code (vec), .i_ext_irq (ext),
    .i_awaddr (awaddr), .i_awvalid (awvalid), .o_awready (awready),
    .i_wdata (wdata), .i_wstrb (wstrb), .i_wvalid (wvalid), .o_wready (wready),
    .o_bresp (bresp), .o_bvalid (bvalid), .i_bready (bready),
    .i_araddr (araddr), .i_arvalid (arvalid), .o_arready (arready),
    .o_rdata (rdata), .o_rresp (rresp), .o_rvalid (rvalid), .i_rready (rready),
    .o_global_irq_enable (glb_en), .o_software_trap_control (swt),
    .o_ext_irq_edge (edges)
  );

  // -----------------------------------------------------------------
  // bus master and checking tasks
  // -----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [4:0] a, input logic [15:0] d, output logic [1:0] rs);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // gather edge pulses over a few cycles after the lines move
  task automatic edge_chk(input logic [2:0] exp);
    logic [2:0] s;
    s = 3'h0;
    repeat (4) begin
      @(posedge clk);
      s = s | edges;
    end
    chk({29'h0, s}, {29'h0, exp});
  endtask

  // hang guard: far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(TSIC_ADDR_CTL2, v, r);
    chk(v, 32'h8000);
    chk({31'h0, glb_en}, 32'h1);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d, r);
      chk({30'h0, r}, {30'h0, rows[k].r});
      rd(rows[k].a, v, r);
      chk(v, {16'h0000, rows[k].e});
      chk({30'h0, r}, {30'h0, rows[k].r});
    end
    wr(TSIC_ADDR_CTL2, 16'h2000, r);
    chk({30'h0, glb_en, swt}, 32'h1);
    core.set_ext(3'h5);
    edge_chk(3'h5);
    wr(TSIC_ADDR_CTL2, 16'h8007, r);
    repeat (3) @(posedge clk);
    core.set_ext(3'h2);
    edge_chk(3'h5);
    for (int k = 0; k < 6; k++) begin
      core.fire(k);
      repeat (3) @(posedge clk);
      rd(fa[k], v, r);
      chk(v, 32'h1 << fb[k]);
      rd(fa[k], v, r);
      chk(v, 32'h1 << fb[k]);
      wr(fa[k], 16'h0000, r);
      rd(fa[k], v, r);
      chk(v, 32'h0);
    end
    core.set_state(1'b1, 4'hF, 7'h7F);
    rd(TSIC_ADDR_CTL2, v, r);
    chk(v, 32'hC007);
    rd(TSIC_ADDR_STAT, v, r);
    chk(v, 32'h0F7F);
    core.set_state(1'b0, 4'h5, 7'h00);
    rd(TSIC_ADDR_STAT, v, r);
    chk(v, 32'h0500);
    // byte strobes: only the enabled lanes may change a register
    @(posedge clk);
    wstrb <= 4'h2;
    wr(TSIC_ADDR_CTL2, 16'h0000, r);
    rd(TSIC_ADDR_CTL2, v, r);
    chk(v, 32'h0007);
    wstrb <= 4'h1;
    wr(TSIC_ADDR_CTL2, 16'hE000, r);
    rd(TSIC_ADDR_CTL2, v, r);
    chk(v, 32'h0000);
    wstrb <= 4'hF;
    // a low clock enable freezes the flags, so this trap goes unseen
    @(posedge clk);
    ce <= 1'b0;
    core.fire(0);
    @(posedge clk);
    ce <= 1'b1;
    rd(TSIC_ADDR_CTL1, v, r);
    chk(v, 32'h0);
    // second reset in mid-run must restore the enable
    wr(TSIC_ADDR_CTL2, 16'h0000, r);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // a line left high across reset must not show up as a new edge
    edge_chk(3'h0);
    chk({31'h0, glb_en}, 32'h1);
    rd(TSIC_ADDR_CTL2, v, r);
    chk(v, 32'h8000);
    conclude();
  end
endmodule
